// ==== design/mfdr_receiver.v ====
`timescale 1ns/10ps
`include "mfdr_defines.vh"

// Notes on behaviour
// - Work only on mu-law coded channels
// - Map tone pairs to digits and controls
// - Tone valid within 1.5 percent plus 5 Hz
// - Pair levels may differ up to 6 dB
// - Accept 0 to -25 dBm0, reject -35
// - Report after 30 ms, never below 10
// - Opening pulse accepted at 30 ms, rejected below 10
// - Bridge dropouts shorter than 10 ms
// - Components may start or stop 4 ms apart
// - Reject coincidence shorter than 10 ms
// - Gaps over 25 ms separate signals
// - Keep up with ten signals per second
// - Locked: report nothing until opening pulse
// - Any terminator relocks the receiver
// - Unlocked: ignore repeated opening pulses
// - More than two tones: report nothing
module mfdr_receiver #(
    parameter SAMPLE_DIV = `MFDR_SAMPLE_DIV
) (
    // Clock and reset
    input  wire        CLK_SYS_IN,
    input  wire        ARST_N_IN,
    // Tone filter front end
    input  wire [5:0]  TONE_PRESENT_IN,
    input  wire [47:0] TONE_DEV_IN,
    input  wire [35:0] TONE_LEVEL_IN,
    // Channel coding strap
    input  wire        CODING_ALAW_IN,
    // Host side
    output reg  [3:0]  DIGIT_CODE_OUT,
    output reg         DIGIT_VALID_OUT,
    output wire        LOCKED_OUT,
    output wire        CODING_FAULT_OUT
);

    // One-hot decision states
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_TONE = 3'h2;
    localparam [2:0] ST_GAP  = 3'h4;

    // Sample counts of the timing figures, cut to the counter width
    localparam integer SIG_THR_I = `MFDR_MS2SMP_UP(`MFDR_SIG_ACC_MS);
    localparam integer KP_THR_I  = `MFDR_MS2SMP_UP(`MFDR_KP_ACC_MS);
    localparam integer REJ_I     = `MFDR_MS2SMP_UP(`MFDR_SIG_REJ_MS);
    localparam integer BRIDGE_I  = `MFDR_MS2SMP_DN(`MFDR_BRIDGE_MS);
    localparam [9:0]   SIG_THR   = SIG_THR_I[9:0];
    localparam [9:0]   KP_THR    = KP_THR_I[9:0];
    localparam [9:0]   REJ_SMP   = REJ_I[9:0];
    localparam [9:0]   BRIDGE    = BRIDGE_I[9:0];
    localparam [9:0]   DUR_MAX   = 10'h3FF;

    // Strap synchroniser and settled coding flag
    reg        alaw_s1_reg;
    reg        alaw_s2_reg;
    reg        alaw_s3_reg;
    reg        alaw_reg;

    // Decision state
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [3:0]  code_reg;
    reg [3:0]  code_next;
    reg [9:0]  dur_reg;
    reg [9:0]  dur_next;
    reg [9:0]  gap_reg;
    reg [9:0]  gap_next;
    reg        bad_reg;
    reg        bad_next;
    reg        done_reg;
    reg        done_next;
    reg        locked_reg;
    reg        locked_next;
    reg [3:0]  out_code_next;
    reg        out_valid_next;

    // Per-sample analysis
    wire       tick;
    wire [5:0] tone_ok;
    reg  [2:0] n_valid;
    reg  [5:0] lvl_a;
    reg  [5:0] lvl_b;
    reg        got_a;
    reg  [5:0] twist;
    reg  [3:0] pair_code;
    reg        pair_known;
    wire       pair_ok;
    wire       excess;
    wire       same;
    wire [9:0] dur_inc;
    wire [9:0] thr;
    wire       fire;
    wire       is_term;
    integer    i;

    // Three-stage strap sampler, change taken when stages two and three agree
    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            alaw_s1_reg <= 1'b0;
            alaw_s2_reg <= 1'b0;
            alaw_s3_reg <= 1'b0;
            alaw_reg    <= 1'b0;
        end else begin
            alaw_s1_reg <= CODING_ALAW_IN;
            alaw_s2_reg <= alaw_s1_reg;
            alaw_s3_reg <= alaw_s2_reg;
            if (alaw_s2_reg == alaw_s3_reg) begin
                alaw_reg <= alaw_s3_reg;
            end
        end
    end

    // Sample enable stops on an unsupported coding
    mfdr_tick_div #(
        .DIV       (SAMPLE_DIV)
    ) u_tick (
        .clk_in    (CLK_SYS_IN),
        .arst_n_in (ARST_N_IN),
        .en_in     (~alaw_reg),
        .tick_out  (tick)
    );

    // One qualifier per tone, tolerance scaled to its nominal frequency
    genvar g;
    generate
        for (g = 0; g < `MFDR_TONES; g = g + 1) begin : g_tone
            localparam integer TOL_I =
                `MFDR_TOL(`MFDR_F0_HZ + `MFDR_F_STEP_HZ * g);
            mfdr_tone_qual #(
                .TOL        (TOL_I[7:0])
            ) u_qual (
                .present_in (TONE_PRESENT_IN[g]),
                .dev_in     (TONE_DEV_IN[g*8 +: 8]),
                .lvl_in     (TONE_LEVEL_IN[g*6 +: 6]),
                .valid_out  (tone_ok[g])
            );
        end
    endgenerate

    // Count valid tones and pick the levels of the first and the last
    always @* begin
        n_valid = 3'h0;
        lvl_a   = 6'h00;
        lvl_b   = 6'h00;
        got_a   = 1'b0;
        for (i = 0; i < `MFDR_TONES; i = i + 1) begin
            if (tone_ok[i]) begin
                n_valid = n_valid + 3'h1;
                if (!got_a) begin
                    lvl_a = TONE_LEVEL_IN[i*6 +: 6];
                    got_a = 1'b1;
                end else begin
                    lvl_b = TONE_LEVEL_IN[i*6 +: 6];
                end
            end
        end
        if (lvl_a > lvl_b) begin
            twist = lvl_a - lvl_b;
        end else begin
            twist = lvl_b - lvl_a;
        end
    end

    // Pair map; bit 0 is the lowest tone, bit 5 the highest
    always @* begin
        pair_known = 1'b1;
        case (tone_ok)
            6'h03:   pair_code = 4'h1;
            6'h05:   pair_code = 4'h2;
            6'h06:   pair_code = 4'h3;
            6'h09:   pair_code = 4'h4;
            6'h0A:   pair_code = 4'h5;
            6'h0C:   pair_code = 4'h6;
            6'h11:   pair_code = 4'h7;
            6'h12:   pair_code = 4'h8;
            6'h14:   pair_code = 4'h9;
            6'h18:   pair_code = 4'h0;
            6'h24:   pair_code = `MFDR_CODE_KP;
            6'h30:   pair_code = `MFDR_CODE_MT;
            6'h22:   pair_code = `MFDR_CODE_TA;
            6'h28:   pair_code = `MFDR_CODE_TB;
            6'h21:   pair_code = `MFDR_CODE_TC;
            default: begin
                pair_code  = 4'h0;
                pair_known = 1'b0;
            end
        endcase
    end

    // A pair counts only with exactly two tones inside the twist window
    assign pair_ok = (n_valid == 3'h2) & pair_known
                   & (twist <= `MFDR_TWIST_DB);
    assign excess  = (n_valid > 3'h2);
    assign same    = pair_ok & (pair_code == code_reg);

    // Coincidence counter saturates so a stuck tone cannot wrap
    assign dur_inc = (dur_reg == DUR_MAX) ? dur_reg : dur_reg + 10'h001;

    // Opening pulse uses its own acceptance time
    assign thr = (code_reg == `MFDR_CODE_KP) ? KP_THR : SIG_THR;

    // Fires once, exactly when coincidence reaches the threshold;
    // thresholds never sit below the rejection time.
    // Idle is excluded: a stale count there must not report a new pair
    assign fire = same & ~bad_reg & ~done_reg & (state_reg != ST_IDLE)
                & (dur_inc == thr) & (thr > REJ_SMP);

    assign is_term = (code_reg == `MFDR_CODE_MT)
                   | (code_reg == `MFDR_CODE_TA)
                   | (code_reg == `MFDR_CODE_TB)
                   | (code_reg == `MFDR_CODE_TC);

    // Decision state machine, advanced once per sample
    always @* begin
        state_next     = state_reg;
        code_next      = code_reg;
        dur_next       = dur_reg;
        gap_next       = gap_reg;
        bad_next       = bad_reg;
        done_next      = done_reg;
        locked_next    = locked_reg;
        out_code_next  = DIGIT_CODE_OUT;
        out_valid_next = 1'b0;
        if (alaw_reg) begin
            state_next = ST_IDLE;
        end else if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    // Lone tone of a skewed start is simply waited out
                    if (pair_ok) begin
                        state_next = ST_TONE;
                        code_next  = pair_code;
                        dur_next   = 10'h001;
                        gap_next   = 10'h000;
                        bad_next   = 1'b0;
                        done_next  = 1'b0;
                    end
                end
                ST_TONE: begin
                    if (excess) begin
                        bad_next = 1'b1;
                    end else if (same) begin
                        dur_next = dur_inc;
                    end else if (pair_ok) begin
                        // New pair with no pause starts a fresh signal
                        code_next = pair_code;
                        dur_next  = 10'h001;
                        bad_next  = 1'b0;
                        done_next = 1'b0;
                    end else begin
                        state_next = ST_GAP;
                        gap_next   = 10'h001;
                    end
                end
                ST_GAP: begin
                    if (excess) begin
                        bad_next = 1'b1;
                        gap_next = 10'h000;
                    end else if (same) begin
                        // Short dropout: same signal resumes
                        state_next = ST_TONE;
                        gap_next   = 10'h000;
                        dur_next   = dur_inc;
                    end else if (pair_ok) begin
                        state_next = ST_TONE;
                        code_next  = pair_code;
                        dur_next   = 10'h001;
                        gap_next   = 10'h000;
                        bad_next   = 1'b0;
                        done_next  = 1'b0;
                    end else if (gap_reg + 10'h001 >= BRIDGE) begin
                        // Pause long enough: signal is over
                        state_next = ST_IDLE;
                        gap_next   = 10'h000;
                    end else begin
                        gap_next = gap_reg + 10'h001;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    gap_next   = 10'h000;
                end
            endcase

            // Acceptance and the lock sequence
            if (fire) begin
                done_next = 1'b1;
                if (locked_reg) begin
                    if (code_reg == `MFDR_CODE_KP) begin
                        locked_next    = 1'b0;
                        out_code_next  = code_reg;
                        out_valid_next = 1'b1;
                    end
                end else if (code_reg == `MFDR_CODE_KP) begin
                    // Repeat opening pulse is consumed silently
                    out_valid_next = 1'b0;
                end else begin
                    out_code_next  = code_reg;
                    out_valid_next = 1'b1;
                    if (is_term) begin
                        locked_next = 1'b1;
                    end
                end
            end
        end
    end

    // State and host registers
    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_reg       <= ST_IDLE;
            code_reg        <= 4'h0;
            dur_reg         <= 10'h000;
            gap_reg         <= 10'h000;
            bad_reg         <= 1'b0;
            done_reg        <= 1'b0;
            locked_reg      <= 1'b1;
            DIGIT_CODE_OUT  <= 4'h0;
            DIGIT_VALID_OUT <= 1'b0;
        end else begin
            state_reg       <= state_next;
            code_reg        <= code_next;
            dur_reg         <= dur_next;
            gap_reg         <= gap_next;
            bad_reg         <= bad_next;
            done_reg        <= done_next;
            locked_reg      <= locked_next;
            DIGIT_CODE_OUT  <= out_code_next;
            DIGIT_VALID_OUT <= out_valid_next;
        end
    end

    // Status straight from flip-flops
    assign LOCKED_OUT       = locked_reg;
    assign CODING_FAULT_OUT = alaw_reg;

endmodule

// ==== design/mfdr_defines.vh ====
`ifndef MFDR_DEFINES_VH
`define MFDR_DEFINES_VH

// System clock and sample stream
`define MFDR_CLK_HZ        50000000
`define MFDR_SAMPLE_HZ     8000
`define MFDR_SAMPLE_DIV    (`MFDR_CLK_HZ / `MFDR_SAMPLE_HZ)

// Millisecond figures of the signal timing
`define MFDR_SIG_ACC_MS    30
`define MFDR_SIG_REJ_MS    10
`define MFDR_KP_ACC_MS     30
`define MFDR_KP_SURE_MS    55
`define MFDR_BRIDGE_MS     10
`define MFDR_SKEW_MS       4
`define MFDR_PAUSE_MS      25

// Least times round up, longest times round down
`define MFDR_MS2SMP_UP(ms) (((ms) * `MFDR_SAMPLE_HZ + 999) / 1000)
`define MFDR_MS2SMP_DN(ms) (((ms) * `MFDR_SAMPLE_HZ) / 1000)

// Tone grid: bit i of a tone vector is F0 + i * STEP
`define MFDR_TONES         6
`define MFDR_F0_HZ         700
`define MFDR_F_STEP_HZ     200

// Tolerance is 1.5 percent plus 5 Hz, rounded down to whole Hz
`define MFDR_TOL_PERMILLE  15
`define MFDR_TOL_OFS_HZ    5
`define MFDR_TOL(f)        (((f) * `MFDR_TOL_PERMILLE) / 1000 + `MFDR_TOL_OFS_HZ)

// Levels in dB below 0 dBm0
`define MFDR_LVL_ACC_DB    25
`define MFDR_LVL_REJ_DB    35
`define MFDR_LVL_LIM_DB    6'h1E
`define MFDR_TWIST_DB      6'h06

// Host codes of the control signals
`define MFDR_CODE_KP       4'hA
`define MFDR_CODE_MT       4'hB
`define MFDR_CODE_TA       4'hC
`define MFDR_CODE_TB       4'hD
`define MFDR_CODE_TC       4'hE

`endif

// ==== design/mfdr_tick_div.v ====
`timescale 1ns/10ps
`include "mfdr_defines.vh"

// Sample-rate enable divider
module mfdr_tick_div #(
    parameter DIV = `MFDR_SAMPLE_DIV
) (
    // Clock and reset
    input  wire clk_in,
    input  wire arst_n_in,
    // Control
    input  wire en_in,
    // Sample enable
    output reg  tick_out
);

    // Terminal count cut to the counter width on purpose
    localparam integer LAST_I = DIV - 1;
    localparam [12:0]  LAST   = LAST_I[12:0];

    reg [12:0] cnt_reg;

    // Counter parks at zero while disabled, so no stale tick leaks out
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg  <= 13'h0000;
            tick_out <= 1'b0;
        end else if (!en_in) begin
            cnt_reg  <= 13'h0000;
            tick_out <= 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_reg  <= 13'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 13'h0001;
            tick_out <= 1'b0;
        end
    end

endmodule

// ==== design/mfdr_tone_qual.v ====
`timescale 1ns/10ps
`include "mfdr_defines.vh"

// Qualifies one tone of the front end
module mfdr_tone_qual #(
    parameter [7:0] TOL = 8'h0F
) (
    // Front end measures
    input  wire       present_in,
    input  wire [7:0] dev_in,
    input  wire [5:0] lvl_in,
    // Verdict
    output wire       valid_out
);

    // Band and level window; weak tones below the limit are dropped
    assign valid_out = present_in
                     & (dev_in <= TOL)
                     & (lvl_in <= `MFDR_LVL_LIM_DB);

endmodule

// ==== verif/mfdr_receiver_properties.sv ====
`timescale 1ns/10ps
// Relations between the receiver host outputs and its inputs
module mfdr_receiver_chk #(
    parameter SAMPLE_DIV = 6250
) (
    // Clock and reset
    input wire        CLK_SYS_IN,
    input wire        ARST_N_IN,
    // Front end and strap
    input wire [5:0]  TONE_PRESENT_IN,
    input wire [47:0] TONE_DEV_IN,
    input wire [35:0] TONE_LEVEL_IN,
    input wire        CODING_ALAW_IN,
    // Host side
    input wire [3:0]  DIGIT_CODE_OUT,
    input wire        DIGIT_VALID_OUT,
    input wire        LOCKED_OUT,
    input wire        CODING_FAULT_OUT
);
    reg [23:0] gap_cnt_reg;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!ARST_N_IN);

    // Edges since the last report; saturates so idle spans never wrap
    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            gap_cnt_reg <= 24'h00_0000;
        else if (DIGIT_VALID_OUT)
            gap_cnt_reg <= 24'h00_0000;
        else if (gap_cnt_reg != 24'hFF_FFFF)
            gap_cnt_reg <= gap_cnt_reg + 24'h00_0001;
    end

    chk_valid_one_cycle: assert property (
        DIGIT_VALID_OUT |=> !DIGIT_VALID_OUT)
        else $error("valid strobe longer than one cycle");
    chk_code_held: assert property (
        !DIGIT_VALID_OUT |-> $stable(DIGIT_CODE_OUT))
        else $error("code moved without a strobe");
    chk_lock_needs_report: assert property (
        $changed(LOCKED_OUT) |-> DIGIT_VALID_OUT)
        else $error("lock changed without a report");
    chk_unlock_code: assert property (
        $fell(LOCKED_OUT) |-> DIGIT_CODE_OUT == 4'hA)
        else $error("unlocked by something other than opening pulse");
    chk_relock_code: assert property (
        $rose(LOCKED_OUT) |-> DIGIT_CODE_OUT inside {[4'hB:4'hE]})
        else $error("relocked by something other than a terminator");
    chk_locked_opening_only: assert property (
        DIGIT_VALID_OUT && $past(LOCKED_OUT) |-> DIGIT_CODE_OUT == 4'hA)
        else $error("report while locked");
    chk_repeat_opening: assert property (
        DIGIT_VALID_OUT && !$past(LOCKED_OUT) |-> DIGIT_CODE_OUT != 4'hA)
        else $error("opening pulse reported while unlocked");
    chk_report_spacing: assert property (
        DIGIT_VALID_OUT |-> gap_cnt_reg >= 239 * SAMPLE_DIV)
        else $error("reports closer than the acceptance time");
    chk_fault_quiet: assert property (
        CODING_FAULT_OUT |-> !DIGIT_VALID_OUT)
        else $error("report with an A-law strap");
    chk_strap_fault: assert property (
        CODING_ALAW_IN [*6] |-> CODING_FAULT_OUT)
        else $error("A-law strap not flagged");
endmodule

bind mfdr_receiver mfdr_receiver_chk #(.SAMPLE_DIV(SAMPLE_DIV)) chk_u (
    .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN),
    .TONE_PRESENT_IN(TONE_PRESENT_IN), .TONE_DEV_IN(TONE_DEV_IN),
    .TONE_LEVEL_IN(TONE_LEVEL_IN), .CODING_ALAW_IN(CODING_ALAW_IN),
    .DIGIT_CODE_OUT(DIGIT_CODE_OUT), .DIGIT_VALID_OUT(DIGIT_VALID_OUT),
    .LOCKED_OUT(LOCKED_OUT), .CODING_FAULT_OUT(CODING_FAULT_OUT));

// ==== verif/mfdr_trunk_model.sv ====
`timescale 1ns/10ps
// Far office tones as seen through the tone filter front end
module mfdr_trunk_model (
    // Clock
    input  wire        clk_in,
    // Tones being sent and their quality
    input  wire [5:0]  mask_in,
    input  wire [7:0]  dev_in,
    input  wire [5:0]  lvl_in,
    input  wire [5:0]  twist_in,
    // Front end measures
    output reg  [5:0]  present_out,
    output reg  [47:0] dev_out,
    output reg  [35:0] lvl_out
);
    reg     flip_reg = 1'b0;
    reg     seen;
    integer k;

    // Absent tones toggle, so a stale measure is never trusted
    always @(negedge clk_in) flip_reg <= ~flip_reg;

    // Lowest tone at nominal level, higher ones twisted down
    always @* begin
        present_out = mask_in;
        seen = 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            if (mask_in[k]) begin
                dev_out[8*k +: 8] = dev_in;
                lvl_out[6*k +: 6] = seen ? 6'(lvl_in + twist_in) : lvl_in;
                seen = 1'b1;
            end else begin
                dev_out[8*k +: 8] = {8{flip_reg}};
                lvl_out[6*k +: 6] = {6{~flip_reg}};
            end
        end
    end
endmodule

// ==== verif/mfdr_receiver_bench.sv ====
`timescale 1ns/10ps
module mfdr_receiver_bench;
    localparam int DIV = 4;
    // Digit masks, code 9 down to code 0; terminators E down to B
    localparam logic [59:0] DIGS = {6'h14, 6'h12, 6'h11, 6'h0C, 6'h0A,
                                    6'h09, 6'h06, 6'h05, 6'h03, 6'h18};
    localparam logic [23:0] TERMS = {6'h21, 6'h28, 6'h22, 6'h30};
    logic        clk_sys;
    logic        arst_n;
    logic        alaw;
    logic [5:0]  mask;
    logic [7:0]  dev;
    logic [5:0]  lvl;
    logic [5:0]  twist;
    wire  [5:0]  present;
    wire  [47:0] tdev;
    wire  [35:0] tlvl;
    wire  [3:0]  code;
    wire         valid;
    wire         locked;
    wire         fault;
    int          error_cnt;
    int          total_checks;
    int          pulse_cnt;
    int          n;

    mfdr_trunk_model trunk_u (
        .clk_in(clk_sys), .mask_in(mask), .dev_in(dev), .lvl_in(lvl),
        .twist_in(twist), .present_out(present), .dev_out(tdev),
        .lvl_out(tlvl));
    mfdr_receiver #(.SAMPLE_DIV(DIV)) dut_u (
        .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n),
        .TONE_PRESENT_IN(present), .TONE_DEV_IN(tdev),
        .TONE_LEVEL_IN(tlvl), .CODING_ALAW_IN(alaw),
        .DIGIT_CODE_OUT(code), .DIGIT_VALID_OUT(valid),
        .LOCKED_OUT(locked), .CODING_FAULT_OUT(fault));

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Strobes counted half a cycle after launch, once settled
    always @(negedge clk_sys) if (valid === 1'b1) pulse_cnt <= pulse_cnt + 1;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task test_done;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole sample periods on, then silent; n gets the strobe count
    task run(input logic [5:0] m, input int on_s, input int off_s);
        int n0;
        n0 = pulse_cnt;
        @(negedge clk_sys);
        mask = m;
        repeat (on_s * DIV) @(negedge clk_sys);
        mask = 6'h00;
        repeat (off_s * DIV) @(negedge clk_sys);
        n = pulse_cnt - n0;
    endtask

    // Mask for a number of sample periods, called at a falling edge
    task hold(input logic [5:0] m, input int s);
        mask = m;
        repeat (s * DIV) @(negedge clk_sys);
    endtask

    // Tones start and stop 30 samples apart, still one signal
    task t_skew;
        int n0;
        n0 = pulse_cnt;
        @(negedge clk_sys);
        hold(6'h01, 30);
        hold(6'h03, 240);
        hold(6'h02, 30);
        hold(6'h00, 100);
        check(pulse_cnt - n0, 1);
        check(code, 4'h1);
    endtask

    task do_reset;
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
    endtask

    task t_reset;
        check(code, 4'h0);
        check(valid, 1'b0);
        check(locked, 1'b1);
        check(fault, 1'b0);
    endtask

    task t_locked;
        run(6'h0A, 300, 100);
        check(n, 0);
        check(locked, 1'b1);
    endtask

    task t_open;
        run(6'h24, 70, 100);
        check(n, 0);
        run(6'h24, 240, 100);
        check(n, 1);
        check(code, 4'hA);
        check(locked, 1'b0);
    endtask

    // Back to back at 60 ms per digit, faster than ten a second
    task t_digits;
        for (int i = 0; i < 10; i++) begin
            run(DIGS[6*i +: 6], 240, 240);
            check(n, 1);
            check(code, i);
        end
    endtask

    task t_repeat_open;
        run(6'h24, 300, 100);
        check(n, 0);
        check(locked, 1'b0);
    endtask

    // Short dropout is one signal; a long pause makes two
    task t_gaps;
        int first;
        run(6'h03, 150, 70);
        first = n;
        run(6'h03, 150, 100);
        check(first + n, 1);
        run(6'h05, 240, 201);
        first = n;
        run(6'h05, 240, 201);
        check(first + n, 2);
    endtask

    task t_short_excess;
        run(6'h05, 79, 100);
        check(n, 0);
        run(6'h07, 300, 100);
        check(n, 0);
        // Extra tone mid-signal taints the whole signal
        n = pulse_cnt;
        hold(6'h05, 100);
        hold(6'h07, 10);
        hold(6'h05, 200);
        hold(6'h00, 100);
        check(pulse_cnt - n, 0);
    endtask

    task qual(input logic [7:0] d, input logic [5:0] l, input logic [5:0] t,
              input int exp);
        dev = d;
        lvl = l;
        twist = t;
        run(6'h03, 240, 100);
        check(n, exp);
        dev = 8'h00;
        lvl = 6'h00;
        twist = 6'h00;
    endtask

    task t_quality;
        qual(8'h0F, 6'h00, 6'h00, 1);
        qual(8'h10, 6'h00, 6'h00, 0);
        qual(8'h00, 6'h1E, 6'h00, 1);
        qual(8'h00, 6'h1F, 6'h00, 0);
        qual(8'h00, 6'h14, 6'h06, 1);
        qual(8'h00, 6'h14, 6'h07, 0);
    endtask

    task t_terms;
        for (int j = 0; j < 4; j++) begin
            run(6'h24, 240, 100);
            check(locked, 1'b0);
            run(TERMS[6*j +: 6], 240, 100);
            check(n, 1);
            check(code, 4'hB + j);
            check(locked, 1'b1);
        end
    endtask

    task t_alaw;
        @(negedge clk_sys);
        alaw = 1'b1;
        repeat (10) @(negedge clk_sys);
        check(fault, 1'b1);
        run(6'h24, 300, 100);
        check(n, 0);
        alaw = 1'b0;
        do_reset();
        check(fault, 1'b0);
        check(locked, 1'b1);
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        pulse_cnt = 0;
        arst_n = 1'b0;
        alaw = 1'b0;
        mask = 6'h00;
        dev = 8'h00;
        lvl = 6'h00;
        twist = 6'h00;
        do_reset();
        t_reset();
        t_locked();
        t_open();
        t_digits();
        t_skew();
        t_repeat_open();
        t_gaps();
        t_short_excess();
        t_quality();
        t_terms();
        t_alaw();
        test_done();
    end

    // Hang guard, about 40 percent above the expected run of about 56000 cycles
    initial begin
        repeat (80000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        test_done();
    end
endmodule
